// [inc/gpfs_pkg.sv]
// Purpose: shared constants for the port1 data / port2 function-select slice
// Assumes: 32-bit APB, byte addresses as printed
// Notes:   function codes are per 2-bit field of the port2 selector
package gpfs_pkg;
    localparam logic [31:0] GPFS_ADDR_P1_LATCH = 32'hFFF8_3018;
    localparam logic [31:0] GPFS_ADDR_P1_SENSE = 32'hFFF8_301C;
    localparam logic [31:0] GPFS_ADDR_P2_FUNC  = 32'hFFF8_3020;
    localparam int          GPFS_P1_PINS       = 2;
    localparam int          GPFS_P2_PINS       = 10;
    localparam logic [1:0]  GPFS_P1_LATCH_RST  = 2'h0;
    localparam logic [19:0] GPFS_P2_FUNC_RST   = 20'h0_0000;
    localparam logic [1:0]  GPFS_FN_GPIO       = 2'h0;
    localparam logic [1:0]  GPFS_FN_PHY        = 2'h1;
    localparam logic [1:0]  GPFS_FN_KEYPAD     = 2'h2;
    localparam int          GPFS_PHY_IN_LAST   = 4;
    localparam int          GPFS_KP_ROW_FIRST  = 8;
    localparam int          GPFS_MDIO_PIN      = 8;
endpackage

// [rtl/gpfs_gpio_slice.sv]
// Purpose: port1 output latch and pin sense, port2 function selector, APB slave
// Assumes: pins and side signals synchronous to clk (40 MHz); sync reset
// Notes:   zero-wait APB; unmapped address answers with pslverr
// How it works
// R1 - port1 pin driven from latch in output mode
// R2 - latch upper bits ignore writes
// R3 - latch resets to zero
// R4 - sense register returns live port1 pin levels
// R5 - sense upper bits read zero
// R6 - ten 2-bit fields, reset to zero
// R7 - code 00 gives general-purpose I/O
// R8 - code 01 gives Ethernet PHY signals
// R9 - code 10 gives keypad columns and rows
// R10 - code 11 reserved, software avoids it
// R11 - port1 output enable only in GPIO mode
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module gpfs_gpio_slice
    import gpfs_pkg::*;
#(
    parameter int P2_PINS = GPFS_P2_PINS
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  port1OutputEnable,
    input  wire logic [3:0]  port1FunctionFields,
    input  wire logic [1:0]  port1PinIn,
    output logic      [1:0]  port1PinOut,
    output logic      [1:0]  port1PinOe,
    input  wire logic [9:0]  port2PinIn,
    output logic      [9:0]  port2PinOut,
    output logic      [9:0]  port2PinOe,
    input  wire logic [9:0]  gpio2OutValue,
    input  wire logic [9:0]  gpio2OutEnable,
    input  wire logic        phyTransmitEnable,
    input  wire logic [1:0]  phyTransmitBits,
    input  wire logic        phyManagementDataOut,
    input  wire logic        phyManagementDataOe,
    input  wire logic        phyManagementClock,
    input  wire logic [1:0]  keypadRowOut,
    output logic             phyReceiveError,
    output logic             phyCarrierSenseValid,
    output logic      [1:0]  phyReceiveBits,
    output logic             phyReferenceClock,
    output logic             phyManagementDataIn,
    output logic      [7:0]  keypadColumnIn
);
    if (P2_PINS != GPFS_P2_PINS) begin : g_chk
        $error("port2 selector serves exactly ten pins");
    end

    logic [1:0]  latch_reg,  latch_next;
    logic [19:0] func_reg,   func_next;
    logic [31:0] rdata_reg,  rdata_next;
    logic        ready_reg,  ready_next;
    logic        err_reg,    err_next;
    logic [1:0]  p1Out_reg,  p1Out_next;
    logic [1:0]  p1Oe_reg,   p1Oe_next;
    logic [9:0]  p2Out_reg,  p2Oe_reg;
    logic [9:0]  muxOut,     muxOe;
    logic [4:0]  phyIn_reg,  muxPhyIn;
    logic        mdIn_reg,   muxMdIn;
    logic [7:0]  kpCol_reg,  muxKpCol;
    logic        setup;
    logic        wrDone;

    // address decode used only for the setup-phase pslverr flag
    function automatic logic isMapped(input logic [31:0] a);
        return (a == GPFS_ADDR_P1_LATCH) || (a == GPFS_ADDR_P1_SENSE) || (a == GPFS_ADDR_P2_FUNC);
    endfunction

    assign setup  = psel && !penable;
    assign wrDone = psel && penable && ready_reg && pwrite;

    // register file and bus answer
    always_comb begin
        latch_next = latch_reg;
        func_next  = func_reg;
        ready_next = setup;
        err_next   = setup && !isMapped(paddr);
        rdata_next = rdata_reg;
        if (wrDone && paddr == GPFS_ADDR_P1_LATCH) begin
            latch_next = pwdata[1:0];                                        // R2
        end
        if (wrDone && paddr == GPFS_ADDR_P2_FUNC) begin
            func_next = pwdata[19:0];                                        // R6
        end
        if (setup) begin
            rdata_next = 32'h0000_0000;                                      // R5
            if (!pwrite && paddr == GPFS_ADDR_P1_LATCH) begin
                rdata_next[1:0] = latch_reg;
            end
            if (!pwrite && paddr == GPFS_ADDR_P1_SENSE) begin
                rdata_next[1:0] = port1PinIn;                                // R4
            end
            if (!pwrite && paddr == GPFS_ADDR_P2_FUNC) begin
                rdata_next[19:0] = func_reg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            latch_reg <= GPFS_P1_LATCH_RST;                                  // R3
            func_reg  <= GPFS_P2_FUNC_RST;                                   // R6
            rdata_reg <= 32'h0000_0000;
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            func_reg  <= func_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            err_reg   <= err_next;
        end
    end

    // port1 pin drive, direction honoured only in GPIO mode
    always_comb begin
        for (int i = 0; i < GPFS_P1_PINS; i++) begin
            p1Oe_next[i]  = port1OutputEnable[i] && (port1FunctionFields[2*i +: 2] == GPFS_FN_GPIO); // R11
            p1Out_next[i] = latch_reg[i];                                    // R1
        end
    end

    gpfs_pin_mux u_mux (
        .funcSel   (func_reg),
        .pinIn     (port2PinIn),
        .gpioOut   (gpio2OutValue),
        .gpioOe    (gpio2OutEnable),
        .phyTxEn   (phyTransmitEnable),
        .phyTxBits (phyTransmitBits),
        .phyMdOut  (phyManagementDataOut),
        .phyMdOe   (phyManagementDataOe),
        .phyMdClk  (phyManagementClock),
        .keypadRow (keypadRowOut),
        .pinOut    (muxOut),
        .pinOe     (muxOe),
        .phyIn     (muxPhyIn),
        .phyMdIn   (muxMdIn),
        .keypadCol (muxKpCol)
    );

    // pin and side-signal output registers
    always_ff @(posedge clk) begin
        if (rst) begin
            p1Out_reg <= 2'h0;
            p1Oe_reg  <= 2'h0;
            p2Out_reg <= 10'h000;
            p2Oe_reg  <= 10'h000;
            phyIn_reg <= 5'h00;
            mdIn_reg  <= 1'b0;
            kpCol_reg <= 8'h00;
        end else begin
            p1Out_reg <= p1Out_next;
            p1Oe_reg  <= p1Oe_next;
            p2Out_reg <= muxOut;                                             // R7
            p2Oe_reg  <= muxOe;
            phyIn_reg <= muxPhyIn;                                           // R8
            mdIn_reg  <= muxMdIn;
            kpCol_reg <= muxKpCol;                                           // R9
        end
    end

    assign prdata               = rdata_reg;
    assign pready               = ready_reg;
    assign pslverr              = err_reg;
    assign port1PinOut          = p1Out_reg;
    assign port1PinOe           = p1Oe_reg;
    assign port2PinOut          = p2Out_reg;
    assign port2PinOe           = p2Oe_reg;
    assign phyReceiveError      = phyIn_reg[0];
    assign phyCarrierSenseValid = phyIn_reg[1];
    assign phyReceiveBits       = phyIn_reg[3:2];
    assign phyReferenceClock    = phyIn_reg[4];
    assign phyManagementDataIn  = mdIn_reg;
    assign keypadColumnIn       = kpCol_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_latch_drive;
        (port1FunctionFields[1:0] == GPFS_FN_GPIO && port1OutputEnable[0])
            |=> (port1PinOe[0] && port1PinOut[0] == $past(latch_reg[0]));
    endproperty
    a_latch_drive: assert property (p_latch_drive) else $error("port1 pin0 not driven from latch"); // R1
    property p_latch_write;
        wrDone && paddr == GPFS_ADDR_P1_LATCH |=> latch_reg == $past(pwdata[1:0]);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write lost"); // R2
    property p_latch_read;
        setup && !pwrite && paddr == GPFS_ADDR_P1_LATCH |=> prdata == {30'h0, $past(latch_reg)};
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch readback wrong"); // R2
    property p_reset;
        disable iff (1'b0) rst |=> (latch_reg == GPFS_P1_LATCH_RST && func_reg == GPFS_P2_FUNC_RST);
    endproperty
    a_reset: assert property (p_reset) else $error("reset value wrong"); // R3
    property p_sense;
        setup && !pwrite && paddr == GPFS_ADDR_P1_SENSE |=> pready && prdata[1:0] == $past(port1PinIn);
    endproperty
    a_sense: assert property (p_sense) else $error("sense read wrong"); // R4
    property p_sense_upper;
        pready && !pwrite && paddr == GPFS_ADDR_P1_SENSE |-> prdata[31:2] == 30'h0;
    endproperty
    a_sense_upper: assert property (p_sense_upper) else $error("sense upper bits set"); // R5
    property p_func_write;
        wrDone && paddr == GPFS_ADDR_P2_FUNC |=> func_reg == $past(pwdata[19:0]) && !pready;
    endproperty
    a_func_write: assert property (p_func_write) else $error("selector write lost"); // R6
    property p_gpio_route;
        func_reg[1:0] == GPFS_FN_GPIO |=> port2PinOe[0] == $past(gpio2OutEnable[0]);
    endproperty
    a_gpio_route: assert property (p_gpio_route) else $error("pin0 gpio route wrong"); // R7
    property p_phy_route;
        func_reg[11:10] == GPFS_FN_PHY |=> port2PinOe[5] && port2PinOut[5] == $past(phyTransmitEnable);
    endproperty
    a_phy_route: assert property (p_phy_route) else $error("pin5 phy route wrong"); // R8
    property p_kp_route;
        func_reg[1:0] == GPFS_FN_KEYPAD && func_reg[17:16] == GPFS_FN_KEYPAD
            |=> keypadColumnIn[0] == $past(port2PinIn[0]) && port2PinOe[8] && !port2PinOe[0];
    endproperty
    a_kp_route: assert property (p_kp_route) else $error("keypad route wrong"); // R9
    property p_p1_oe;
        port1FunctionFields[3:2] != GPFS_FN_GPIO |=> !port1PinOe[1];
    endproperty
    a_p1_oe: assert property (p_p1_oe) else $error("port1 pin1 driven outside gpio"); // R11
    c_latch_wr: cover property (wrDone && paddr == GPFS_ADDR_P1_LATCH);
    c_sense_rd: cover property (pready && !pwrite && paddr == GPFS_ADDR_P1_SENSE);
    c_phy_mode: cover property (func_reg[11:10] == GPFS_FN_PHY && port2PinOe[5]);
    c_unmapped: cover property (pslverr);
endmodule // gpfs_gpio_slice
`default_nettype wire

// [rtl/gpfs_pin_mux.sv]
// Purpose: routes the ten port2 pins by their 2-bit function fields
// Assumes: purely combinational, registered by the parent
// Notes:   reserved code leaves the pin undriven and feeds nothing
`timescale 1ns/1ps
`default_nettype none
module gpfs_pin_mux
    import gpfs_pkg::*;
(
    input  wire logic [19:0] funcSel,
    input  wire logic [9:0]  pinIn,
    input  wire logic [9:0]  gpioOut,
    input  wire logic [9:0]  gpioOe,
    input  wire logic        phyTxEn,
    input  wire logic [1:0]  phyTxBits,
    input  wire logic        phyMdOut,
    input  wire logic        phyMdOe,
    input  wire logic        phyMdClk,
    input  wire logic [1:0]  keypadRow,
    output logic      [9:0]  pinOut,
    output logic      [9:0]  pinOe,
    output logic      [4:0]  phyIn,
    output logic             phyMdIn,
    output logic      [7:0]  keypadCol
);
    logic [9:0] phyOutVec;
    logic [9:0] phyOeVec;
    logic [9:0] kpOutVec;
    logic [9:0] kpOeVec;

    // per-function output and enable vectors
    assign phyOutVec = {phyMdClk, phyMdOut, phyTxBits, phyTxEn, 5'h00};      // R8
    assign phyOeVec  = {1'b1, phyMdOe, 3'h7, 5'h00};                         // R8
    assign kpOutVec  = {keypadRow, 8'h00};                                   // R9
    assign kpOeVec   = 10'h300;                                              // R9

    // select per pin
    always_comb begin
        pinOut    = '0;
        pinOe     = '0;
        phyIn     = '0;
        phyMdIn   = 1'b0;
        keypadCol = '0;
        for (int i = 0; i < GPFS_P2_PINS; i++) begin
            case (funcSel[2*i +: 2])
                GPFS_FN_GPIO: begin                                          // R7
                    pinOut[i] = gpioOut[i];
                    pinOe[i]  = gpioOe[i];
                end
                GPFS_FN_PHY: begin                                           // R8
                    pinOut[i] = phyOutVec[i];
                    pinOe[i]  = phyOeVec[i];
                    if (i == GPFS_MDIO_PIN) begin
                        phyMdIn = pinIn[i];
                    end
                end
                GPFS_FN_KEYPAD: begin                                        // R9
                    pinOut[i] = kpOutVec[i];
                    pinOe[i]  = kpOeVec[i];
                end
                default: begin                                               // R10
                    pinOut[i] = 1'b0;
                    pinOe[i]  = 1'b0;
                end
            endcase
        end
        // function inputs, looped only over the pins that carry them so no index runs past a vector
        for (int i = 0; i <= GPFS_PHY_IN_LAST; i++) begin
            if (funcSel[2*i +: 2] == GPFS_FN_PHY) begin                      // R8
                phyIn[i] = pinIn[i];
            end
        end
        for (int i = 0; i < GPFS_KP_ROW_FIRST; i++) begin
            if (funcSel[2*i +: 2] == GPFS_FN_KEYPAD) begin                   // R9
                keypadCol[i] = pinIn[i];
            end
        end
    end
endmodule // gpfs_pin_mux
`default_nettype wire

// [tb/gpfs_board_model.sv]
// Purpose: board circuitry on the port1 and port2 pins
// Assumes: board yields every pin that the slice drives
// Notes:   undriven pins show the level the bench puts on the board side
`timescale 1ns/1ps
`default_nettype none
module gpfs_board_model (
    input  wire logic [1:0] p1Out,
    input  wire logic [1:0] p1Oe,
    input  wire logic [1:0] p1Ext,
    output logic      [1:0] p1Level,
    input  wire logic [9:0] p2Out,
    input  wire logic [9:0] p2Oe,
    input  wire logic [9:0] p2Ext,
    output logic      [9:0] p2Level
);
    // wire level: slice value where it drives, board value elsewhere
    assign p1Level = (p1Oe & p1Out) | (~p1Oe & p1Ext);
    assign p2Level = (p2Oe & p2Out) | (~p2Oe & p2Ext);
endmodule // gpfs_board_model
`default_nettype wire

// [tb/gpfs_gpio_slice_tb.sv]
// Purpose: self-checking bench for the port1 data / port2 selector slice
// Assumes: zero-wait APB slave, pin paths one register stage deep
// Notes:   pin checks wait three cycles after each stimulus change
`timescale 1ns/1ps
`default_nettype none
module gpfs_gpio_slice_tb;
    import gpfs_pkg::*;
    logic        clk = 1'b0;
    logic        rst, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [1:0]  p1Oen, p1Out, p1Oe, p1Ext, p1Level, phyBits, kpRow, rxBits;
    logic [3:0]  p1Fields;
    logic [9:0]  p2Out, p2Oe, p2Ext, p2Level, g2Val, g2Oe;
    logic        txEn, mdOut, mdOe, mdClk, rxErr, crs, refClk, mdIn;
    logic [7:0]  kpCol;
    int          num_errors = 0;
    int          comparisons = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    gpfs_gpio_slice #(.P2_PINS(10)) i_gpfs_gpio_slice (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port1OutputEnable(p1Oen), .port1FunctionFields(p1Fields), .port1PinIn(p1Level),
        .port1PinOut(p1Out), .port1PinOe(p1Oe), .port2PinIn(p2Level), .port2PinOut(p2Out), .port2PinOe(p2Oe),
        .gpio2OutValue(g2Val), .gpio2OutEnable(g2Oe), .phyTransmitEnable(txEn), .phyTransmitBits(phyBits),
        .phyManagementDataOut(mdOut), .phyManagementDataOe(mdOe), .phyManagementClock(mdClk),
        .keypadRowOut(kpRow), .phyReceiveError(rxErr), .phyCarrierSenseValid(crs), .phyReceiveBits(rxBits),
        .phyReferenceClock(refClk), .phyManagementDataIn(mdIn), .keypadColumnIn(kpCol));

    gpfs_board_model i_gpfs_board_model (.p1Out(p1Out), .p1Oe(p1Oe), .p1Ext(p1Ext), .p1Level(p1Level),
        .p2Out(p2Out), .p2Oe(p2Oe), .p2Ext(p2Ext), .p2Level(p2Level));

    // one comparison, counted
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one APB transfer; read data and error taken at the pready edge
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       input logic [31:0] exp, input logic expErr);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, {31'h0, pready});
        chk("pslverr", {31'h0, expErr}, {31'h0, pslverr});
        if (!w) chk("prdata", exp, prdata);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // program one code into all ten fields, then check the pins
    task automatic check_mode(input logic [1:0] m);
        logic [31:0] fv;
        fv = 32'h0;
        for (int i = 0; i < 10; i++) fv[2*i +: 2] = m;
        acc(1'b1, GPFS_ADDR_P2_FUNC, fv, 32'h0, 1'b0);
        acc(1'b0, GPFS_ADDR_P2_FUNC, 32'h0, fv, 1'b0);
        repeat (3) @(posedge clk);
        if (m == GPFS_FN_GPIO) begin
            chk("gpioOe", {22'h0, g2Oe}, {22'h0, p2Oe});
            chk("gpioOut", {22'h0, g2Val & g2Oe}, {22'h0, p2Out & p2Oe});
            chk("gpioSide", 32'h0, {18'h0, rxErr, crs, rxBits, refClk, mdIn, kpCol});
        end else if (m == GPFS_FN_PHY) begin
            chk("phyOe", 32'h2E0, {22'h0, p2Oe});
            chk("phyOut", 32'h2A0, {22'h0, p2Out & 10'h2E0});
            chk("phyIn", {26'h0, p2Ext[0], p2Ext[1], p2Ext[3:2], p2Ext[4], p2Ext[8]},
                {26'h0, rxErr, crs, rxBits, refClk, mdIn});
            chk("phyKpCol", 32'h0, {24'h0, kpCol});
            // management data turned to drive: pin 8 shows the slice value, not the board's high
            mdOe <= 1'b1;
            repeat (3) @(posedge clk);
            chk("phyMdio", 32'h2, {30'h0, p2Oe[8], p2Out[8]});
            chk("phyMdIn", 32'h0, {31'h0, mdIn});
            mdOe <= 1'b0;
        end else begin
            chk("kpOe", 32'h300, {22'h0, p2Oe});
            chk("kpRow", 32'h2, {30'h0, p2Out[9:8]});
            chk("kpCol", {24'h0, p2Ext[7:0]}, {18'h0, rxErr, crs, rxBits, refClk, mdIn, kpCol});
        end
    endtask

    // verdict and end of run
    task automatic print_verdict;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    // main sequence
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
        p1Oen = 2'h0; p1Fields = 4'h0; p1Ext = 2'h2; p2Ext = 10'h115; g2Val = 10'h2A5; g2Oe = 10'h3F0;
        txEn = 1'b1; phyBits = 2'h2; mdOut = 1'b0; mdOe = 1'b0; mdClk = 1'b1; kpRow = 2'h2;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, GPFS_ADDR_P1_LATCH, 32'h0, 32'h0, 1'b0);
        acc(1'b0, GPFS_ADDR_P2_FUNC, 32'h0, 32'h0, 1'b0);
        acc(1'b0, GPFS_ADDR_P1_SENSE, 32'h0, 32'h2, 1'b0);
        acc(1'b1, GPFS_ADDR_P1_LATCH, 32'hFFFF_FFFD, 32'h0, 1'b0);
        acc(1'b0, GPFS_ADDR_P1_LATCH, 32'h0, 32'h1, 1'b0);
        p1Oen <= 2'h3;
        repeat (3) @(posedge clk);
        chk("p1Out", 32'h1, {30'h0, p1Out});
        chk("p1Oe", 32'h3, {30'h0, p1Oe});
        acc(1'b0, GPFS_ADDR_P1_SENSE, 32'h0, 32'h1, 1'b0);
        p1Fields <= 4'h4;
        repeat (3) @(posedge clk);
        chk("p1OeFn", 32'h1, {30'h0, p1Oe});
        p1Oen <= 2'h2;
        repeat (3) @(posedge clk);
        chk("p1OeOff", 32'h0, {30'h0, p1Oe});
        acc(1'b1, GPFS_ADDR_P1_SENSE, 32'h3, 32'h0, 1'b0);
        acc(1'b1, 32'hFFF8_3024, 32'h2, 32'h0, 1'b1);
        acc(1'b0, 32'hFFF8_3024, 32'h0, 32'h0, 1'b1);
        acc(1'b0, GPFS_ADDR_P1_LATCH, 32'h0, 32'h1, 1'b0);
        // every defined function code; code 11 is never programmed
        for (int m = 0; m < 3; m++) check_mode(m[1:0]);
        // mid-run reset must clear a non-zero latch and selector again
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, GPFS_ADDR_P1_LATCH, 32'h0, 32'h0, 1'b0);
        acc(1'b0, GPFS_ADDR_P2_FUNC, 32'h0, 32'h0, 1'b0);
        print_verdict();
    end
endmodule // gpfs_gpio_slice_tb
`default_nettype wire
